// file: core/efr_pkg.sv
package efr_pkg;

    // ----------------------------------------------------------------
    // Bus geometry
    // ----------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;  // Sticky fault flags, read only
    localparam logic [ADDR_W-1:0] OFS_CLEAR = 8'h04;   // Write one to clear, write only
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h08;  // Interrupt enable, same layout
    localparam logic [ADDR_W-1:0] OFS_INJECT = 8'h0c;  // Fake fault injection, write only
    localparam logic [ADDR_W-1:0] OFS_LIVE = 8'h10;    // Live source levels, read only
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h14;    // Control

    // Reset values
    localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0001;
    localparam logic [DATA_W-1:0] IRQ_EN_RST = 32'h0000_0000;

    // Control field positions
    localparam int CTRL_ROUTE_EN = 0;  // Drive the fault lines when set

    // ----------------------------------------------------------------
    // Routed lines: bit positions in status, clear, enable, inject
    // ----------------------------------------------------------------
    localparam int NUM_LINES = 10;
    localparam int LN_XCHK = 0;
    localparam int LN_HSM = 1;
    localparam int LN_ETH0 = 2;
    localparam int LN_ETH1 = 3;
    localparam int LN_TTBUS = 4;
    localparam int LN_OSMI = 5;
    localparam int LN_EMMC = 6;
    localparam int LN_USB = 7;
    localparam int LN_SIL0 = 8;
    localparam int LN_SIL1 = 9;

    // Lines that accept fake injection (crossbar checker line does not)
    localparam logic [NUM_LINES-1:0] INJECTABLE = 10'h3fe;

    // Fault collection unit input numbers
    localparam int FAULT_W = 128;
    localparam int FN_XCHK = 90;
    localparam int FN_HSM = 110;
    localparam int FN_ETH0 = 97;
    localparam int FN_ETH1 = 53;
    localparam int FN_TTBUS = 60;
    localparam int FN_OSMI = 105;
    localparam int FN_EMMC = 106;
    localparam int FN_USB = 104;
    localparam int FN_SIL0 = 113;
    localparam int FN_SIL1 = 114;

    // ----------------------------------------------------------------
    // Post-ECC observation ports: index of each ECC data path
    // ----------------------------------------------------------------
    localparam int NUM_ECC = 11;
    localparam int SRC_HSM = 0;
    localparam int SRC_ETH0 = 1;
    localparam int SRC_ETH1 = 2;
    localparam int SRC_TTBUS = 3;
    localparam int SRC_OSMI = 4;
    localparam int SRC_EMMC_M = 5;
    localparam int SRC_EMMC_S = 6;
    localparam int SRC_USB_M = 7;
    localparam int SRC_USB_S = 8;
    localparam int SRC_SIL0 = 9;
    localparam int SRC_SIL1 = 10;

    // One RAM read as seen before and after the correction logic
    typedef struct packed {
        logic valid;                // Read data present this cycle
        logic raw_ok;               // Syndrome of raw word shows no error
        logic [DATA_W-1:0] raw;     // Word as read from RAM
        logic [DATA_W-1:0] fixed;   // Word leaving the correction logic
    } efr_ecc_obs_t;

    // Error levels that need no post-ECC check
    typedef struct packed {
        logic xchk_c0;              // Crossbar integrity checker in concentrator 0
        logic ttbus_master;         // Transaction error of time-triggered bus master
        logic usb_master_ecc;       // ECC error reported on the USB master port
    } efr_direct_err_t;

endpackage : efr_pkg

// file: core/efr_post_ecc_chk.sv
// Flags a correction that altered a word the syndrome called clean
module efr_post_ecc_chk (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Observed read
    input wire efr_pkg::efr_ecc_obs_t i_obs,
    // Corrupted correction pulse
    output logic o_corrupt
);

    // ----------------------------------------------------------------
    // Compare raw and corrected word
    // ----------------------------------------------------------------

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_corrupt <= 1'b0;
        end else begin
            // Only a clean raw word must pass through unchanged
            o_corrupt <= i_obs.valid & i_obs.raw_ok & (i_obs.raw != i_obs.fixed);
        end
    end

endmodule // efr_post_ecc_chk

// file: core/efr_fault_router.sv
// Summary of operation
// - Concentrator crossbar checker drives input 90, uninjectable
// - Security-core concentrator ECC fault drives input 110
// - Ethernet 0/1 corrupted correction drive 97, 53
// - Input 60 ORs bus ECC and master error
// - Octal memory interface corrupted correction drives 105
// - eMMC master or slave correction drives 106
// - USB master error or corrections drive 104
// - Inter-chip links 0/1 drive inputs 113, 114
// - Flag clean RAM data altered by correction
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
module efr_fault_router (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // AXI4-Lite write address
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [efr_pkg::ADDR_W-1:0] i_awaddr,
    input wire logic [2:0] i_awprot,
    // AXI4-Lite write data
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [efr_pkg::DATA_W-1:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // AXI4-Lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // AXI4-Lite read address
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [efr_pkg::ADDR_W-1:0] i_araddr,
    input wire logic [2:0] i_arprot,
    // AXI4-Lite read data
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [efr_pkg::DATA_W-1:0] o_rdata,
    output logic [1:0] o_rresp,
    // Monitor observations
    input wire efr_pkg::efr_ecc_obs_t [efr_pkg::NUM_ECC-1:0] i_ecc_obs,
    input wire efr_pkg::efr_direct_err_t i_direct,
    // Toward the fault collection unit
    output logic [efr_pkg::FAULT_W-1:0] o_fault_lines,
    // Interrupt
    output logic o_irq
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic rst_meta_n;                               // Reset synchroniser, first stage
    logic rst_n;                                    // Synchronised reset for the block
    logic [efr_pkg::NUM_ECC-1:0] corrupt;           // Post-ECC checker pulses
    logic [efr_pkg::NUM_LINES-1:0] live;            // Current hardware event per line
    logic [efr_pkg::NUM_LINES-1:0] status;          // Sticky flags per line
    logic [efr_pkg::NUM_LINES-1:0] irq_en;          // Interrupt enable per line
    logic [efr_pkg::DATA_W-1:0] ctrl;               // Control register
    logic [efr_pkg::NUM_LINES-1:0] clr_req;         // Clear bits written this cycle
    logic [efr_pkg::NUM_LINES-1:0] inj_req;         // Injection bits written this cycle
    logic wr_fire;                                  // Write taken this cycle
    logic rd_fire;                                  // Read taken this cycle
    logic [efr_pkg::DATA_W-1:0] wdata_m;            // Write data with byte lanes applied
    logic wr_hit;                                   // Write address is mapped
    logic [efr_pkg::DATA_W-1:0] next_rdata;         // Read mux result
    logic rd_hit;                                   // Read address is mapped

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------

    // Word-aligned register offset of a byte address
    function automatic logic [efr_pkg::ADDR_W-1:0] word_ofs(input logic [efr_pkg::ADDR_W-1:0] addr);
        word_ofs = {addr[efr_pkg::ADDR_W-1:2], 2'h0};
    endfunction

    // True when the offset names a register
    function automatic logic is_mapped(input logic [efr_pkg::ADDR_W-1:0] ofs);
        is_mapped = (ofs == efr_pkg::OFS_STATUS) || (ofs == efr_pkg::OFS_CLEAR) ||
                    (ofs == efr_pkg::OFS_IRQ_EN) || (ofs == efr_pkg::OFS_INJECT) ||
                    (ofs == efr_pkg::OFS_LIVE) || (ofs == efr_pkg::OFS_CTRL);
    endfunction

    // Zero-extend a line vector to a bus word
    function automatic logic [efr_pkg::DATA_W-1:0] to_word(input logic [efr_pkg::NUM_LINES-1:0] v);
        to_word = {{(efr_pkg::DATA_W-efr_pkg::NUM_LINES){1'b0}}, v};
    endfunction

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------

    // Assert at once, release after two clock edges
    // No unaligned release reaches the block
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // ----------------------------------------------------------------
    // Post-ECC checkers, one per protected data path
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < efr_pkg::NUM_ECC; gi++) begin : g_chk
            // per-path post-ECC check
            // One cycle behind the read
            efr_post_ecc_chk efr_post_ecc_chk_i (
                .i_clk(i_ref_clk),
                .i_rst_n(rst_n),
                .i_obs(i_ecc_obs[gi]),
                .o_corrupt(corrupt[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Source merging per fault line
    // ----------------------------------------------------------------

    // Combine monitor indications into one event per line
    always_comb begin
        live = '0;
        live[efr_pkg::LN_XCHK] = i_direct.xchk_c0;
        live[efr_pkg::LN_HSM] = corrupt[efr_pkg::SRC_HSM];
        live[efr_pkg::LN_ETH0] = corrupt[efr_pkg::SRC_ETH0];
        live[efr_pkg::LN_ETH1] = corrupt[efr_pkg::SRC_ETH1];
        live[efr_pkg::LN_TTBUS] = corrupt[efr_pkg::SRC_TTBUS] | i_direct.ttbus_master;
        live[efr_pkg::LN_OSMI] = corrupt[efr_pkg::SRC_OSMI];
        live[efr_pkg::LN_EMMC] = corrupt[efr_pkg::SRC_EMMC_M] | corrupt[efr_pkg::SRC_EMMC_S];
        live[efr_pkg::LN_USB] = i_direct.usb_master_ecc | corrupt[efr_pkg::SRC_USB_M] |
                                corrupt[efr_pkg::SRC_USB_S];
        live[efr_pkg::LN_SIL0] = corrupt[efr_pkg::SRC_SIL0];
        live[efr_pkg::LN_SIL1] = corrupt[efr_pkg::SRC_SIL1];
    end

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------

    // Address and data are taken together once no response waits
    // Taking both keeps a write paired;
    // a lone channel waits unbuffered
    assign o_awready = i_awvalid & i_wvalid & ~o_bvalid;
    assign o_wready = i_awvalid & i_wvalid & ~o_bvalid;
    assign wr_fire = i_awvalid & i_wvalid & ~o_bvalid;

    // Read address taken while no read data waits
    assign o_arready = ~o_rvalid;
    assign rd_fire = i_arvalid & ~o_rvalid;

    // Decode of the taken addresses
    assign wr_hit = is_mapped(word_ofs(i_awaddr));
    assign rd_hit = is_mapped(word_ofs(i_araddr));

    // Byte lanes that are not strobed write zero
    // so partial writes clear the bits of unstrobed lanes
    always_comb begin
        wdata_m = '0;
        for (int b = 0; b < 4; b++) begin
            wdata_m[b*8 +: 8] = i_wstrb[b] ? i_wdata[b*8 +: 8] : 8'h00;
        end
    end

    // Write strobes toward the event registers
    assign clr_req = (wr_fire && word_ofs(i_awaddr) == efr_pkg::OFS_CLEAR) ?
                     wdata_m[efr_pkg::NUM_LINES-1:0] : '0;
    assign inj_req = (wr_fire && word_ofs(i_awaddr) == efr_pkg::OFS_INJECT) ?
                     wdata_m[efr_pkg::NUM_LINES-1:0] : '0;

    // ----------------------------------------------------------------
    // Write response
    // ----------------------------------------------------------------

    // One response per taken write, held until accepted
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_bvalid <= 1'b0;
            o_bresp <= efr_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            // Unmapped address answers with a slave error
            o_bvalid <= 1'b1;
            o_bresp <= wr_hit ? efr_pkg::RESP_OKAY : efr_pkg::RESP_SLVERR;
        end else if (i_bready) begin
            // Response accepted
            o_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------

    // Control register
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= efr_pkg::CTRL_RST;
        end else if (wr_fire && word_ofs(i_awaddr) == efr_pkg::OFS_CTRL) begin
            // Only the route enable bit is kept
            // Zero silences the fault lines, not the interrupt; keeps flags
            ctrl <= {{(efr_pkg::DATA_W-1){1'b0}}, wdata_m[efr_pkg::CTRL_ROUTE_EN]};
        end
    end

    // Interrupt enable register
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_en <= efr_pkg::IRQ_EN_RST[efr_pkg::NUM_LINES-1:0];
        end else if (wr_fire && word_ofs(i_awaddr) == efr_pkg::OFS_IRQ_EN) begin
            // Upper bits are dropped
            irq_en <= wdata_m[efr_pkg::NUM_LINES-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Sticky fault flags
    // ----------------------------------------------------------------

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= '0;
        end else begin
            // Written zeros leave their flag alone
            // A new event or injection in the clear cycle wins over the clear;
            // the crossbar line ignores injection
            status <= (status & ~clr_req) | live | (inj_req & efr_pkg::INJECTABLE);
        end
    end

    // ----------------------------------------------------------------
    // Fault collection unit outputs
    // ----------------------------------------------------------------

    // Place each sticky flag on its numbered input
    // Unrouted inputs stay low
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_fault_lines <= '0;
        end else begin
            o_fault_lines <= '0;
            if (ctrl[efr_pkg::CTRL_ROUTE_EN]) begin
                o_fault_lines[efr_pkg::FN_XCHK] <= status[efr_pkg::LN_XCHK];
                o_fault_lines[efr_pkg::FN_HSM] <= status[efr_pkg::LN_HSM];
                o_fault_lines[efr_pkg::FN_ETH0] <= status[efr_pkg::LN_ETH0];
                o_fault_lines[efr_pkg::FN_ETH1] <= status[efr_pkg::LN_ETH1];
                o_fault_lines[efr_pkg::FN_TTBUS] <= status[efr_pkg::LN_TTBUS];
                o_fault_lines[efr_pkg::FN_OSMI] <= status[efr_pkg::LN_OSMI];
                o_fault_lines[efr_pkg::FN_EMMC] <= status[efr_pkg::LN_EMMC];
                o_fault_lines[efr_pkg::FN_USB] <= status[efr_pkg::LN_USB];
                o_fault_lines[efr_pkg::FN_SIL0] <= status[efr_pkg::LN_SIL0];
                o_fault_lines[efr_pkg::FN_SIL1] <= status[efr_pkg::LN_SIL1];
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt
    // ----------------------------------------------------------------

    // Level output while any enabled flag is set
    // Registered, so it cannot glitch
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(status & irq_en);
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------

    // Select the addressed register
    // Reads have no side effects
    always_comb begin
        next_rdata = '0;
        unique case (word_ofs(i_araddr))
            efr_pkg::OFS_STATUS: begin
                next_rdata = to_word(status);
            end
            efr_pkg::OFS_IRQ_EN: begin
                next_rdata = to_word(irq_en);
            end
            efr_pkg::OFS_LIVE: begin
                // Current, not latched, events
                next_rdata = to_word(live);
            end
            efr_pkg::OFS_CTRL: begin
                next_rdata = ctrl;
            end
            default: begin
                // Write-only and unmapped offsets read zero
                next_rdata = '0;
            end
        endcase
    end

    // Read data held until accepted
    // New address waits for the last answer
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= efr_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            o_rvalid <= 1'b1;
            o_rdata <= next_rdata;
            o_rresp <= rd_hit ? efr_pkg::RESP_OKAY : efr_pkg::RESP_SLVERR;
        end else if (i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

endmodule // efr_fault_router

// file: tb/efr_fcu_model.sv
// Behavioural fault collection unit on the far side of the routed lines
module efr_fcu_model (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Routed lines and software recovery
    input wire logic [127:0] i_lines,
    input wire logic i_clr,
    // Alarm state
    output logic o_alarm
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_alarm <= 1'b0;
        end else if (|i_lines) begin
            // A live fault wins over recovery
            o_alarm <= 1'b1;
        end else if (i_clr) begin
            o_alarm <= 1'b0;
        end
    end
endmodule // efr_fcu_model

// file: tb/efr_properties.sv
// Timing checks of the routed fault lines
module efr_properties (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Write address handshake
    input wire logic i_awvalid,
    input wire logic o_awready,
    // Monitor inputs and routed lines
    input wire efr_pkg::efr_ecc_obs_t [efr_pkg::NUM_ECC-1:0] i_ecc_obs,
    input wire efr_pkg::efr_direct_err_t i_direct,
    input wire logic [efr_pkg::FAULT_W-1:0] o_fault_lines
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    logic take;  // Register write accepted
    assign take = i_awvalid && o_awready;
    // Clean word altered by the correction logic
    function automatic logic corr(input efr_pkg::efr_ecc_obs_t o);
        return o.valid && o.raw_ok && (o.raw != o.fixed);
    endfunction
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);
    // Corruption on one data path
    sequence s_hit(int i);
        corr(i_ecc_obs[i]);
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_crossbar;
        $rose(o_fault_lines[90]) |-> $past(i_direct.xchk_c0, 2);
    endproperty
    property p_hsm;
        s_hit(0) |-> ##3 o_fault_lines[110];
    endproperty
    property p_eth;
        (s_hit(1) |-> ##3 o_fault_lines[97]) and (s_hit(2) |-> ##3 o_fault_lines[53]);
    endproperty
    property p_ttbus;
        (s_hit(3) |-> ##3 o_fault_lines[60]) and (i_direct.ttbus_master |-> ##2 o_fault_lines[60]);
    endproperty
    property p_osmi;
        s_hit(4) |-> ##3 o_fault_lines[105];
    endproperty
    property p_emmc;
        corr(i_ecc_obs[5]) || corr(i_ecc_obs[6]) |-> ##3 o_fault_lines[106];
    endproperty
    property p_usb;
        (corr(i_ecc_obs[7]) || corr(i_ecc_obs[8]) |-> ##3 o_fault_lines[104])
            and (i_direct.usb_master_ecc |-> ##2 o_fault_lines[104]);
    endproperty
    property p_link;
        (s_hit(9) |-> ##3 o_fault_lines[113]) and (s_hit(10) |-> ##3 o_fault_lines[114]);
    endproperty
    property p_clean;
        $rose(o_fault_lines[105]) |-> $past(corr(i_ecc_obs[4]), 3) || $past(take, 2);
    endproperty
    property p_hold;
        $fell(o_fault_lines[97]) |-> $past(take, 2);
    endproperty
    a_crossbar: assert property (p_crossbar) else $error("line 90 rose without its checker");
    a_hsm: assert property (p_hsm) else $error("line 110 missed");
    a_eth: assert property (p_eth) else $error("line 97 or 53 missed");
    a_ttbus: assert property (p_ttbus) else $error("line 60 missed");
    a_osmi: assert property (p_osmi) else $error("line 105 missed");
    a_emmc: assert property (p_emmc) else $error("line 106 missed");
    a_usb: assert property (p_usb) else $error("line 104 missed");
    a_link: assert property (p_link) else $error("line 113 or 114 missed");
    a_clean: assert property (p_clean) else $error("line 105 rose without cause");
    a_hold: assert property (p_hold) else $error("line 97 fell without a clear");
endmodule // efr_properties

bind efr_fault_router efr_properties efr_properties_i (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_ecc_obs(i_ecc_obs), .i_direct(i_direct), .o_fault_lines(o_fault_lines)
);

// file: tb/efr_fault_router_test.sv
// Self-checking bench of the fault router
module efr_fault_router_test;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic i_ref_clk = 1'b0, i_rst_n = 1'b0, fcu_clr = 1'b0;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
    logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata, rv;
    logic [3:0] i_wstrb = 4'h0;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq, fcu_alarm;
    logic [1:0] o_bresp, o_rresp, last_b;
    logic [127:0] o_fault_lines;
    efr_pkg::efr_ecc_obs_t [10:0] i_ecc_obs = '0;
    efr_pkg::efr_direct_err_t i_direct = '0;
    logic [33:0] exp_q[$];  // Expected {resp, data} of each read
    int mismatches = 0, tests_run = 0, seed = 81;
    localparam int FN[10] = '{90, 110, 97, 53, 60, 105, 106, 104, 113, 114};
    efr_fault_router efr_fault_router_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr), .i_awprot(3'h0),
        .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
        .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid),
        .o_arready(o_arready), .i_araddr(i_araddr), .i_arprot(3'h0), .o_rvalid(o_rvalid),
        .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp), .i_ecc_obs(i_ecc_obs),
        .i_direct(i_direct), .o_fault_lines(o_fault_lines), .o_irq(o_irq));
    efr_fcu_model efr_fcu_model_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_lines(o_fault_lines), .i_clr(fcu_clr), .o_alarm(fcu_alarm));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    initial forever #20 i_ref_clk = ~i_ref_clk;
    task automatic summarize();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic ok);
        tests_run++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[ERR] %0t unexpected value", $time);
        end
    endtask
    // Hold a request until the edge that samples its answer high
    task automatic edge_when(input int w);
        logic seen;
        seen = 1'b0;
        while (!seen) begin
            @(negedge i_ref_clk);
            seen = (w == 0) ? (o_awready & o_wready) : (w == 1) ? o_bvalid : (w == 2) ? o_arready : o_rvalid;
            last_b = o_bresp;
            @(posedge i_ref_clk);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_awaddr <= a;
        i_wdata <= d;
        i_wstrb <= 4'hf;
        i_bready <= 1'b1;
        edge_when(0);
        i_awvalid <= 1'b0;
        i_wvalid <= 1'b0;
        edge_when(1);
        i_bready <= 1'b0;
        chk(last_b === e);
        @(posedge i_ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        i_arvalid <= 1'b1;
        i_araddr <= a;
        i_rready <= 1'b1;
        edge_when(2);
        i_arvalid <= 1'b0;
        edge_when(3);
        i_rready <= 1'b0;
        @(posedge i_ref_clk);
    endtask
    // Kinds: 0 clean-syndrome read, 1 direct level, 2 injection, 3 flagged read
    task automatic fire(input int k, input int s, input logic [31:0] v, input logic [9:0] m);
        logic [127:0] x;
        logic [31:0] r;
        x = '0;
        r = $random(seed);
        for (int b = 0; b < 10; b++) x[FN[b]] = m[b];
        if (k == 2) begin
            wr(8'h0c, v, 2'h0);
        end else if (k == 1) begin
            i_direct <= v[2:0];
        end else begin
            i_ecc_obs[s] <= {1'b1, k == 0, r, r ^ v};
        end
        @(posedge i_ref_clk);
        i_ecc_obs[s].valid <= 1'b0;
        i_direct <= '0;
        repeat (6) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        chk(o_fault_lines === x);
        chk(o_irq === m[2] && fcu_alarm === |m);
        @(posedge i_ref_clk);
        rd(8'h00, {2'h0, 22'h0, m});
        wr(8'h04, 32'h3ff, 2'h0);
        repeat (2) @(posedge i_ref_clk);
        fcu_clr <= 1'b1;
        @(posedge i_ref_clk);
        fcu_clr <= 1'b0;
        @(negedge i_ref_clk);
        chk(o_fault_lines === '0 && o_irq === 1'b0 && fcu_alarm === 1'b0);
        @(posedge i_ref_clk);
    endtask
    // Each read answer against the oldest note
    always @(negedge i_ref_clk) begin
        if (o_rvalid === 1'b1 && i_rready === 1'b1) begin
            chk(exp_q.size() > 0 && {o_rresp, o_rdata} === exp_q.pop_front());
        end
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        rd(8'h00, 34'h0);
        rd(8'h08, 34'h0);
        rd(8'h14, {2'h0, 32'h1});
        rd(8'h40, {2'h2, 32'h0});
        wr(8'h40, 32'hffff_ffff, 2'h2);
        wr(8'h08, 32'h4, 2'h0);
        rd(8'h08, {2'h0, 32'h4});
        wr(8'h14, 32'h0, 2'h0);
        i_direct <= 3'h4;
        wr(8'h0c, 32'h20, 2'h0);
        rd(8'h10, {2'h0, 32'h1});
        i_direct <= '0;
        rd(8'h00, {2'h0, 32'h21});
        @(negedge i_ref_clk);
        chk(o_fault_lines === '0 && o_irq === 1'b0);
        @(posedge i_ref_clk);
        wr(8'h04, 32'h3ff, 2'h0);
        wr(8'h14, 32'h1, 2'h0);
        for (int s = 0; s < 11; s++) begin
            fire(0, s, 32'h1 << s, 10'h1 << (s + 1 - (s > 5) - (s > 7)));
            fire(0, s, 32'h0, 10'h0);
            fire(3, s, 32'h1, 10'h0);
        end
        fire(1, 0, 32'h4, 10'h001);
        fire(1, 0, 32'h2, 10'h010);
        fire(1, 0, 32'h1, 10'h080);
        for (int b = 0; b < 10; b++) fire(2, 0, 32'h1 << b, (10'h1 << b) & 10'h3fe);
        rv = $random(seed);
        fire(2, 0, rv & 32'h3ff, rv[9:0] & 10'h3fe);
        summarize();
    end
    // Watchdog
    initial begin
        #400000;
        mismatches++;
        summarize();
    end
endmodule // efr_fault_router_test
